// ===== obl_option_loader.sv
`timescale 1ns/1ps
module obl_option_loader (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  res_pin_n_in,
  input  wire logic                  freeze_pin_in,
  input  wire logic                  readout_guard_in,
  input  wire logic                  freeze_instr_in,
  input  wire obl_pkg::obl_axil_req_type axil_req_in,
  output obl_pkg::obl_axil_rsp_type  axil_rsp_out,
  output logic                       fetch_start_out,
  output logic [13:0]                fetch_addr_out,
  output logic                       cpu_run_out,
  output logic                       frozen_out,
  output logic                       wdt_en_out,
  output logic                       osc_ceramic_out,
  output logic [1:0]                 port_ab_level_out,
  output logic                       ports_float_out,
  output obl_pkg::obl_pins_type      pullup_out,
  output obl_pkg::obl_pins_type      input_en_out
);

  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    obl_pkg::obl_state_type st;
    logic [2:0]             cnt;
    logic [7:0][7:0]        opt;
    logic                   run;
    logic                   fetch;
    logic                   wdt;
    logic                   osc;
    logic                   flt;
    logic [1:0]             lvl;
    obl_pkg::obl_pins_type  pull;
    obl_pkg::obl_pins_type  ien;
    logic [13:0]            paddr;
    logic [7:0]             pdata;
    logic [7:0]             prd;
    logic                   perr;
    logic                   aw_hold;
    logic [7:0]             aw_addr;
    logic                   w_hold;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } obl_core_type;

  obl_core_type r;
  obl_core_type r_nxt;

  logic        res_s;
  logic        frz_s;
  logic        grd_s;
  logic        prom_we;
  logic [13:0] prom_addr;
  logic [7:0]  prom_rd;
  logic        prom_ok;
  logic        awready;
  logic        wready;
  logic        arready;

  ////////////////////////////////////////////////////////////////////
  obl_sync #(
    .W (3)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({res_pin_n_in, freeze_pin_in, readout_guard_in}),
    .q_out    ({res_s, frz_s, grd_s})
  );

  obl_prom u_prom (
    .mclk_in     (mclk_in),
    .wr_en_in    (prom_we),
    .wr_addr_in  (r.paddr),
    .wr_data_in  (r.pdata),
    .rd_addr_in  (prom_addr),
    .rd_data_out (prom_rd),
    .rd_ok_out   (prom_ok)
  );

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // Pin pull-up map from the option bytes
  function automatic obl_pkg::obl_pins_type
      pins_of(input logic [7:0][7:0] o);
    obl_pkg::obl_pins_type p;
    p.a = o[obl_pkg::B_AB][3:0];
    p.a[2] = p.a[2] | o[obl_pkg::B_EXTRA][obl_pkg::XA2_BIT];
    p.a[3] = p.a[3] | o[obl_pkg::B_EXTRA][obl_pkg::XA3_BIT];
    p.b = o[obl_pkg::B_AB][7:4];
    p.c = o[obl_pkg::B_CD][3:0];
    p.d = o[obl_pkg::B_CD][6:4];
    p.e = o[obl_pkg::B_EF][3:0];
    p.f = o[obl_pkg::B_EF][7:4];
    p.g = o[obl_pkg::B_G][3:0];
    pins_of = p;
  endfunction

  ////////////////////////////////////////////////////////////////////
  assign awready = !r.aw_hold && !r.bvalid;
  assign wready  = !r.w_hold && !r.bvalid;
  assign arready = !r.rvalid;

  always_comb begin
    r_nxt     = r;
    r_nxt.fetch = 1'b0;
    prom_we   = 1'b0;
    prom_addr = r.paddr;

    // Load sequencing
    case (r.st)
      obl_pkg::ST_RESET: begin
        if (res_s) begin
          r_nxt.st  = obl_pkg::ST_LOAD;
          r_nxt.cnt = 3'd0;
        end
      end
      obl_pkg::ST_LOAD: begin
        // One option byte per cycle, all eight before run
        prom_addr = obl_pkg::OPT_BASE + {11'd0, r.cnt};
        r_nxt.opt[r.cnt] = prom_rd;
        if (r.cnt == 3'(obl_pkg::LOAD_CYC - 1)) begin
          r_nxt.st    = obl_pkg::ST_RUN;
          r_nxt.run   = 1'b1;
          r_nxt.fetch = 1'b1;
        end else begin
          r_nxt.cnt = r.cnt + 3'd1;
        end
      end
      obl_pkg::ST_RUN: begin
        if (!res_s) begin
          r_nxt.st = obl_pkg::ST_RESET;
        end else if (freeze_instr_in && !frz_s) begin
          r_nxt.st = obl_pkg::ST_FREEZE;
        end
      end
      obl_pkg::ST_FREEZE: begin
        // Reset pin not looked at until the freeze pin rises
        if (frz_s) begin
          // Reset still low at exit goes straight to reset
          r_nxt.st = res_s ? obl_pkg::ST_RUN
                           : obl_pkg::ST_RESET;
        end
      end
      default: begin
        r_nxt.st = obl_pkg::ST_RESET;
      end
    endcase

    if (r_nxt.st == obl_pkg::ST_RESET) begin
      r_nxt.run = 1'b0;
    end

    // Outputs: reset view until the load has completed
    if (r_nxt.st == obl_pkg::ST_RESET || r_nxt.st == obl_pkg::ST_LOAD) begin
      r_nxt.pull = '0;
      r_nxt.flt  = 1'b1;
      r_nxt.wdt  = 1'b0;
    end else begin
      r_nxt.pull = pins_of(r_nxt.opt);
      r_nxt.flt  = 1'b0;
      r_nxt.wdt  = r_nxt.opt[obl_pkg::B_MAIN][obl_pkg::WDT_BIT];
    end
    // Groups a and b keep their selected level through reset
    r_nxt.lvl = {r_nxt.opt[obl_pkg::B_MAIN][obl_pkg::LVL_B],
                 r_nxt.opt[obl_pkg::B_MAIN][obl_pkg::LVL_A]};
    r_nxt.osc = r_nxt.opt[obl_pkg::B_MAIN][obl_pkg::OSC_BIT];
    // Pull-up on c, d and g is a push-pull stage
    r_nxt.ien   = '1;
    r_nxt.ien.c = ~r_nxt.pull.c;
    r_nxt.ien.d = ~r_nxt.pull.d;
    r_nxt.ien.g = ~r_nxt.pull.g;

    ////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    if (axil_req_in.awvalid && awready) begin
      r_nxt.aw_hold = 1'b1;
      r_nxt.aw_addr = axil_req_in.awaddr[7:0];
    end
    if (axil_req_in.wvalid && wready) begin
      r_nxt.w_hold = 1'b1;
      r_nxt.w_data = axil_req_in.wdata;
      r_nxt.w_strb = axil_req_in.wstrb;
    end
    if (r.bvalid && axil_req_in.bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold) begin
      r_nxt.aw_hold = 1'b0;
      r_nxt.w_hold  = 1'b0;
      r_nxt.bvalid  = 1'b1;
      r_nxt.bresp   = obl_pkg::RESP_OKAY;
      case (r.aw_addr)
        obl_pkg::REG_PADDR: begin
          r_nxt.paddr = 14'(merge({18'd0, r.paddr}, r.w_data, r.w_strb));
        end
        obl_pkg::REG_PDATA: begin
          r_nxt.pdata = 8'(merge({24'd0, r.pdata}, r.w_data, r.w_strb));
        end
        obl_pkg::REG_PCMD: begin
          if (r.w_strb[0]) begin
            if (r.w_data[obl_pkg::CMD_WR]) begin
              // Programming blocked by guard, load or range
              if (grd_s || r.st == obl_pkg::ST_LOAD ||
                  r.paddr >= obl_pkg::PROM_END) begin
                r_nxt.perr = 1'b1;
              end else begin
                prom_we    = 1'b1;
                r_nxt.perr = 1'b0;
              end
            end
            if (r.w_data[obl_pkg::CMD_RD]) begin
              // Guard on: secure; guard off: lines float
              r_nxt.prd  = grd_s ? obl_pkg::GUARD_DATA
                                 : obl_pkg::FLOAT_DATA;
              r_nxt.perr = 1'b1;
            end
          end
        end
        default: begin
          r_nxt.bresp = obl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (r.rvalid && axil_req_in.rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (axil_req_in.arvalid && arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = obl_pkg::RESP_OKAY;
      r_nxt.rdata  = 32'h0000_0000;
      case (axil_req_in.araddr[7:0])
        obl_pkg::REG_STATUS: begin
          r_nxt.rdata[1:0] = r.st;
          r_nxt.rdata[obl_pkg::ST_RUN_BIT] = r.run;
          r_nxt.rdata[obl_pkg::ST_FRZ_BIT] =
            (r.st == obl_pkg::ST_FREEZE);
          r_nxt.rdata[obl_pkg::ST_GRD_BIT] = grd_s;
          r_nxt.rdata[obl_pkg::ST_ERR_BIT] = r.perr;
        end
        obl_pkg::REG_PADDR: r_nxt.rdata[13:0] = r.paddr;
        obl_pkg::REG_PDATA: r_nxt.rdata[7:0] = r.pdata;
        obl_pkg::REG_RDATA: begin
          r_nxt.rdata[7:0] = r.prd;
          r_nxt.rdata[obl_pkg::RD_ERR_BIT] = r.perr;
        end
        obl_pkg::REG_OPT_LO: r_nxt.rdata = r.opt[3:0];
        obl_pkg::REG_OPT_HI: r_nxt.rdata = r.opt[7:4];
        obl_pkg::REG_PCMD: r_nxt.rdata = 32'h0000_0000;
        default: begin
          r_nxt.rresp = obl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r       <= '0;
      r.st    <= obl_pkg::ST_RESET;
      r.flt   <= 1'b1;
      r.ien   <= '1;
      r.paddr <= obl_pkg::PADDR_RST;
      r.pdata <= obl_pkg::PDATA_RST;
    end else begin
      r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign axil_rsp_out.awready = awready;
  assign axil_rsp_out.wready  = wready;
  assign axil_rsp_out.bvalid  = r.bvalid;
  assign axil_rsp_out.bresp   = r.bresp;
  assign axil_rsp_out.arready = arready;
  assign axil_rsp_out.rvalid  = r.rvalid;
  assign axil_rsp_out.rdata   = r.rdata;
  assign axil_rsp_out.rresp   = r.rresp;

  assign fetch_start_out   = r.fetch;
  assign fetch_addr_out    = obl_pkg::FETCH_START;
  assign cpu_run_out       = r.run;
  assign frozen_out        = (r.st == obl_pkg::ST_FREEZE);
  assign wdt_en_out        = r.wdt;
  assign osc_ceramic_out   = r.osc;
  assign port_ab_level_out = r.lvl;
  assign ports_float_out   = r.flt;
  assign pullup_out        = r.pull;
  assign input_en_out      = r.ien;

endmodule

// ===== obl_pkg.sv
// What this block does
// - Low PROM is code, 2000H-2007H hold options
// - Option byte 0 sets watchdog, group levels
// - Option byte 0 bit 4 picks oscillator
// - Byte 2001H sets groups a, b pull-up
// - Byte 2002H sets groups c, d; D7 ignored
// - Byte 2003H sets groups e and f
// - Byte 2004H low nibble sets group g
// - Byte 2007H D2, D3 add pins a2, a3
// - PROM answers only below 2008H
// - Reset makes pins open-drain and floating
// - Pin configuration applied eleven cycles after reset release
// - Fetch starts at 0000H after loading
// - Readout guard protects PROM contents
// - Push-pull pins lose their input path
// - Freeze on pin low and instruction
// - Reset ignored while frozen
package obl_pkg;

  localparam int          PA_W        = 14;
  localparam logic [13:0] OPT_BASE    = 14'h2000;
  localparam logic [13:0] PROM_END    = 14'h2008;
  localparam logic [13:0] FETCH_START = 14'h0000;
  localparam int          OPT_COUNT   = 8;

  // Option byte indexes and field positions
  localparam int B_MAIN  = 0;
  localparam int B_AB    = 1;
  localparam int B_CD    = 2;
  localparam int B_EF    = 3;
  localparam int B_G     = 4;
  localparam int B_EXTRA = 7;
  localparam int WDT_BIT = 0;
  localparam int LVL_A   = 1;
  localparam int LVL_B   = 2;
  localparam int OSC_BIT = 4;
  localparam int XA2_BIT = 2;
  localparam int XA3_BIT = 3;

  // Times in instruction cycles; one clock is one instruction cycle
  localparam int CLK_PER_TCYC = 1;
  localparam int LOAD_TCYC    = 8;
  localparam int RES_MIN_TCYC = 3;
  localparam int LOAD_CYC     = LOAD_TCYC * CLK_PER_TCYC;
  localparam int RES_MIN_CYC  = RES_MIN_TCYC * CLK_PER_TCYC;

  // Register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PADDR  = 8'h04;
  localparam logic [7:0] REG_PDATA  = 8'h08;
  localparam logic [7:0] REG_PCMD   = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_OPT_LO = 8'h14;
  localparam logic [7:0] REG_OPT_HI = 8'h18;
  localparam int CMD_WR     = 0;
  localparam int CMD_RD     = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_FRZ_BIT = 3;
  localparam int ST_GRD_BIT = 4;
  localparam int ST_ERR_BIT = 5;
  localparam int RD_ERR_BIT = 8;
  localparam logic [13:0] PADDR_RST  = 14'h0000;
  localparam logic [7:0]  PDATA_RST  = 8'h00;
  localparam logic [7:0]  FLOAT_DATA = 8'hff;
  localparam logic [7:0]  GUARD_DATA = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_LOAD   = 2'b01,
    ST_RUN    = 2'b10,
    ST_FREEZE = 2'b11
  } obl_state_type;

  // Per-pin configuration, one bit per pin
  typedef struct packed {
    logic [3:0] g;
    logic [3:0] f;
    logic [3:0] e;
    logic [2:0] d;
    logic [3:0] c;
    logic [3:0] b;
    logic [3:0] a;
  } obl_pins_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } obl_axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } obl_axil_rsp_type;

endpackage

// ===== obl_sync.sv
`timescale 1ns/1ps
module obl_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } obl_sync_type;

  obl_sync_type r;
  obl_sync_type r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = d_in;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign q_out = r.s2;

endmodule

// ===== obl_prom.sv
`timescale 1ns/1ps
module obl_prom #(
  parameter int AW    = obl_pkg::PA_W,
  parameter int DEPTH = obl_pkg::PROM_END
) (
  input  wire logic          mclk_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [7:0]    rd_data_out,
  output logic               rd_ok_out
);

  logic [7:0] mem [DEPTH];

  function automatic logic in_range(input logic [AW-1:0] a);
    in_range = (a < obl_pkg::PROM_END);
  endfunction

  always_ff @(posedge mclk_in) begin
    if (wr_en_in && in_range(wr_addr_in)) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Out-of-range reads return zero and drop the ok flag
  always_comb begin
    rd_ok_out   = in_range(rd_addr_in);
    rd_data_out = 8'h00;
    if (rd_ok_out) begin
      rd_data_out = mem[rd_addr_in];
    end
  end

endmodule

// ===== obl_loader_properties.sv
`timescale 1ns/1ps
module obl_loader_checker (
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic                  res_pin_n_in,
  input wire logic                  freeze_pin_in,
  input wire logic                  freeze_instr_in,
  input wire logic                  fetch_start_out,
  input wire logic [13:0]           fetch_addr_out,
  input wire logic                  cpu_run_out,
  input wire logic                  frozen_out,
  input wire logic                  wdt_en_out,
  input wire logic                  osc_ceramic_out,
  input wire logic [1:0]            port_ab_level_out,
  input wire logic                  ports_float_out,
  input wire obl_pkg::obl_pins_type pullup_out,
  input wire obl_pkg::obl_pins_type input_en_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence release_s;
    ports_float_out && !frozen_out && $rose(res_pin_n_in);
  endsequence
  sequence fetch_s;
    fetch_start_out && fetch_addr_out == 14'h0000 ##1 !fetch_start_out;
  endsequence
  // Both pins seen through two flops, so look two samples back
  sequence frz_req_s;
    cpu_run_out && !frozen_out && freeze_instr_in && res_pin_n_in &&
    $past(res_pin_n_in) && $past(res_pin_n_in, 2) && !freeze_pin_in &&
    !$past(freeze_pin_in) && !$past(freeze_pin_in, 2);
  endsequence

  load_window_a: assert property (
    release_s |-> ports_float_out [*8] ##[1:4] fetch_s)
    else $error("pin configuration not applied in time");
  fetch_pulse_a: assert property (
    fetch_start_out |-> (cpu_run_out && !ports_float_out) ##0 fetch_s)
    else $error("bad fetch start");
  run_rise_a: assert property (
    $rose(cpu_run_out) |-> fetch_start_out)
    else $error("run without fetch start");
  float_reset_a: assert property (
    ports_float_out |-> pullup_out == '0 && !cpu_run_out)
    else $error("pins not open-drain in reset");
  wdt_off_a: assert property (
    !cpu_run_out |-> !wdt_en_out)
    else $error("watchdog on while not running");
  cmos_input_a: assert property (
    input_en_out == {~pullup_out.g, 8'hff, ~pullup_out.d, ~pullup_out.c,
                     8'hff})
    else $error("push-pull pin still usable as input");
  config_hold_a: assert property (
    cpu_run_out && !frozen_out && $past(cpu_run_out) && !$past(frozen_out)
    |-> $stable(pullup_out) && $stable(osc_ceramic_out) &&
        $stable(port_ab_level_out))
    else $error("latched options changed while running");
  freeze_entry_a: assert property (
    frz_req_s |=> frozen_out)
    else $error("freeze not entered");
  freeze_hold_a: assert property (
    frozen_out && !$past(freeze_pin_in) && !$past(freeze_pin_in, 2)
    |=> frozen_out && !ports_float_out)
    else $error("left freeze while request held");
endmodule

////////////////////////////////////////////////////////////////////////////
bind obl_option_loader obl_loader_checker chk_u (
  .mclk_in          (mclk_in),
  .rst_n_in         (rst_n_in),
  .res_pin_n_in     (res_pin_n_in),
  .freeze_pin_in    (freeze_pin_in),
  .freeze_instr_in  (freeze_instr_in),
  .fetch_start_out  (fetch_start_out),
  .fetch_addr_out   (fetch_addr_out),
  .cpu_run_out      (cpu_run_out),
  .frozen_out       (frozen_out),
  .wdt_en_out       (wdt_en_out),
  .osc_ceramic_out  (osc_ceramic_out),
  .port_ab_level_out(port_ab_level_out),
  .ports_float_out  (ports_float_out),
  .pullup_out       (pullup_out),
  .input_en_out     (input_en_out)
);

// ===== obl_pin_src.sv
`timescale 1ns/1ps
module obl_pin_src (
  input  wire logic mclk_in,
  output logic      res_pin_n_out,
  output logic      freeze_pin_out
);
  initial begin
    res_pin_n_out = 1'b0;
    freeze_pin_out = 1'b1;
  end
  task automatic res_low();
    @(posedge mclk_in);
    res_pin_n_out <= 1'b0;
  endtask
  task automatic frz_low();
    @(posedge mclk_in);
    freeze_pin_out <= 1'b0;
  endtask
  // Slow sources pass a larger n; never shorter than three cycles
  task automatic res_high(input int n);
    @(posedge mclk_in);
    freeze_pin_out <= 1'b1;
    repeat ((n < obl_pkg::RES_MIN_CYC) ? obl_pkg::RES_MIN_CYC : n)
      @(posedge mclk_in);
    res_pin_n_out <= 1'b1;
  endtask
endmodule

// ===== option_byte_loader_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module option_byte_loader_tb_top;
  typedef struct packed {
    logic [63:0]           opt;
    obl_pkg::obl_pins_type pu;
    logic [3:0]            misc;
  } obl_row_type;
  // Row 1 sets ignored bits 2002H D7 and the 2004H high nibble on purpose
  obl_row_type rows [3] = '{
    '{64'h0, 27'h0, 4'h0},
    '{64'h0c00_00f9_3cff_a517, {4'h9, 4'h3, 4'hc, 3'h7, 4'hf, 4'ha, 4'hd},
      4'hf},
    '{64'h0400_0000_0000_0001, 27'h4, 4'h1}};
  logic [13:0] pa [3] = '{14'h2001, 14'h2008, 14'h2007};
  logic        pe [3] = '{1'b0, 1'b1, 1'b0};
  logic                      mclk_in = 1'b0;
  logic                      rst_n_in = 1'b0;
  logic                      guard = 1'b0;
  logic                      frz_instr = 1'b0;
  logic                      res_n, frz_pin, fetch, frozen, wdt, osc, flt;
  logic                      run;
  logic [13:0]               faddr;
  logic [1:0]                lvl, br, rr;
  logic [31:0]               rd;
  obl_pkg::obl_pins_type     pu;
  obl_pkg::obl_pins_type     ien, xi;
  obl_pkg::obl_axil_rsp_type rsp;
  obl_pkg::obl_axil_req_type req =
    '{bready: 1'b1, rready: 1'b1, wstrb: 4'hf, default: '0};
  int                        n_errors = 0;
  int                        n_checks = 0;

  always #12.5 mclk_in = ~mclk_in;

  obl_pin_src src_u (
    .mclk_in       (mclk_in),
    .res_pin_n_out (res_n),
    .freeze_pin_out(frz_pin)
  );
  obl_option_loader dut_u (
    .mclk_in          (mclk_in),
    .rst_n_in         (rst_n_in),
    .res_pin_n_in     (res_n),
    .freeze_pin_in    (frz_pin),
    .readout_guard_in (guard),
    .freeze_instr_in  (frz_instr),
    .axil_req_in      (req),
    .axil_rsp_out     (rsp),
    .fetch_start_out  (fetch),
    .fetch_addr_out   (faddr),
    .cpu_run_out      (run),
    .frozen_out       (frozen),
    .wdt_en_out       (wdt),
    .osc_ceramic_out  (osc),
    .port_ab_level_out(lvl),
    .ports_float_out  (flt),
    .pullup_out       (pu),
    .input_en_out     (ien)
  );

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      n_errors++;
      summarize();
    end
  endtask
  // Ready bits are sampled before this edge's updates land
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    br = rsp.bresp;
    tmo(n);
  endtask
  task automatic ard(input logic [7:0] a);
    int n;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rd = rsp.rdata;
    rr = rsp.rresp;
    tmo(n);
  endtask
  task automatic prog(input logic [13:0] a, input logic [7:0] d);
    axw(obl_pkg::REG_PADDR, {18'h0, a});
    axw(obl_pkg::REG_PDATA, {24'h0, d});
    axw(obl_pkg::REG_PCMD, 32'h1);
  endtask
  task automatic wait_fetch();
    int n;
    for (n = 0; n < 40 && fetch !== 1'b1; n++) @(posedge mclk_in);
    tmo(n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    ard(obl_pkg::REG_STATUS);
    `CHK("status", 32'h0, rd)
    foreach (rows[i]) begin
      src_u.res_low();
      for (int b = 0; b < obl_pkg::OPT_COUNT; b++) begin
        prog(obl_pkg::OPT_BASE + 14'(b), rows[i].opt[8*b +: 8]);
      end
      src_u.res_high(3);
      wait_fetch();
      `CHK("pullup", rows[i].pu, pu)
      `CHK("misc", rows[i].misc, {osc, lvl, wdt})
      `CHK("start", {1'b1, obl_pkg::FETCH_START}, {run, faddr})
      // Pull-up on groups c, d and g is push-pull: no input path
      xi = '1;
      xi.c = ~rows[i].pu.c;
      xi.d = ~rows[i].pu.d;
      xi.g = ~rows[i].pu.g;
      `CHK("inen", xi, ien)
      ard(obl_pkg::REG_OPT_LO);
      `CHK("opt_lo", rows[i].opt[31:0], rd)
      ard(obl_pkg::REG_OPT_HI);
      `CHK("opt_hi", rows[i].opt[63:32], rd)
    end
    foreach (pa[i]) begin
      prog(pa[i], 8'hff);
      ard(obl_pkg::REG_STATUS);
      `CHK("perr", pe[i], rd[5])
    end
    `CHK("keep", 27'h4, pu)
    for (int g = 1; g >= 0; g--) begin
      guard <= g[0];
      repeat (3) @(posedge mclk_in);
      prog(14'h0005, 8'h00);
      ard(obl_pkg::REG_STATUS);
      `CHK("guard", {g[0], g[0]}, rd[5:4])
      axw(obl_pkg::REG_PCMD, 32'h2);
      ard(obl_pkg::REG_RDATA);
      `CHK("readback", (g == 1) ? 32'h100 : 32'h1ff, rd)
    end
    axw(8'h1c, 32'h0);
    `CHK("bresp", obl_pkg::RESP_SLVERR, br)
    ard(8'h1c);
    `CHK("rresp", obl_pkg::RESP_SLVERR, rr)
    src_u.frz_low();
    repeat (3) @(posedge mclk_in);
    frz_instr <= 1'b1;
    @(posedge mclk_in);
    frz_instr <= 1'b0;
    @(posedge mclk_in);
    `CHK("frozen", 1'b1, frozen)
    ard(obl_pkg::REG_STATUS);
    `CHK("status_frz", 32'h2f, rd)
    src_u.res_low();
    repeat (5) @(posedge mclk_in);
    `CHK("hold", 2'b10, {frozen, flt})
    src_u.res_high(4);
    wait_fetch();
    `CHK("reload", 27'hff, pu)
    summarize();
  end
endmodule
